// ### design/mcr_params.svh
// Constants for the magnetometer calibration register bank.
// Assumes inclusion by the package and design files of that bank.
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

// ****************************************************************
// Register offsets within advanced features page 0
// ****************************************************************
`define MCR_ADDR_SENS_LOW    8'hBA
`define MCR_ADDR_SENS_HIGH   8'hBB
`define MCR_ADDR_HIX_LOW     8'hC0
`define MCR_ADDR_HIX_HIGH    8'hC1
`define MCR_ADDR_HIY_LOW     8'hC2
`define MCR_ADDR_HIY_HIGH    8'hC3
`define MCR_ADDR_HIZ_LOW     8'hC4
`define MCR_ADDR_HIZ_HIGH    8'hC5
`define MCR_ADDR_C11_LOW     8'hC6
`define MCR_ADDR_C11_HIGH    8'hC7
`define MCR_ADDR_C12_LOW     8'hC8
`define MCR_ADDR_C12_HIGH    8'hC9

// ****************************************************************
// Page selection and reset values
// ****************************************************************
`define MCR_PAGE_ZERO        4'h0
`define MCR_RST_SENS_LOW     8'h24
`define MCR_RST_SENS_HIGH    8'h16
`define MCR_RST_ZERO         8'h00
`define MCR_RST_C11_HIGH     8'h3C
`define MCR_NUM_REGS         12

`endif

// ### design/mcr_pkg.sv
// Types shared by the magnetometer calibration register bank.
// Assumes mcr_params.svh sits in the include path.
package mcr_pkg;
    `include "mcr_params.svh"

    // One calibration byte
    typedef logic [7:0]  mcr_byte_t;
    // One assembled calibration word
    typedef logic [15:0] mcr_word_t;
    // Index of a byte slot within the bank
    typedef logic [3:0]  mcr_idx_t;
endpackage

// ### design/mcr_byte_reg.sv
// One read/write calibration byte with its own reset value.
// Assumes a synchronous active-high reset on core_clk.
`timescale 1ns/1ns
module mcr_byte_reg
    import mcr_pkg::*;
#(
    parameter mcr_byte_t RESET_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      reset,
    // Write side
    input  wire logic      writeEnable,
    input  wire mcr_byte_t writeData,
    // Stored value
    output mcr_byte_t      value
);

    mcr_byte_t valueReg;

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Byte keeps its value until written or reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            valueReg <= RESET_VALUE;
        end else if (writeEnable) begin
            valueReg <= writeData;
        end
    end

    assign value = valueReg;

endmodule

// ### design/mcr_calib_regs.sv
// Magnetometer calibration register bank, advanced features page 0.
// Assumes the page access logic presents a decoded address, a page number,
// a write strobe and a read strobe, all in the core_clk domain.
//
// Overview of operation
// - A 16-bit external magnetometer sensitivity resets to 0x1624, 0.0015 gauss per LSB.
// - The sensitivity low byte sits at BAh and the high byte at BBh, which resets to 0x16.
// - The X hard-iron offset uses C0h low and C1h high, both resetting to zero.
// - The Y hard-iron offset uses C2h low and C3h high, both resetting to zero.
// - The Z hard-iron offset uses C4h low and C5h high, both resetting to zero.
// - The soft-iron coefficient 11 uses C6h low and C7h high, resetting to 0x3C00.
// - One coefficient at C8h and C9h serves both the 12 and 21 matrix positions.
// - Every calibration byte is host readable and writable and feeds the state machine.
`timescale 1ns/1ns
`include "mcr_params.svh"
module mcr_calib_regs
    import mcr_pkg::*;
(
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      reset,
    // Page window access
    input  wire logic [3:0] pageSel,
    input  wire mcr_byte_t pageAddr,
    input  wire logic      pageWrite,
    input  wire logic      pageRead,
    input  wire mcr_byte_t pageWriteData,
    output mcr_byte_t      pageReadData,
    output logic           pageHit,
    // Values for the embedded state machine
    output mcr_word_t      extMagSensitivity,
    output mcr_word_t      hardIronOffsetX,
    output mcr_word_t      hardIronOffsetY,
    output mcr_word_t      hardIronOffsetZ,
    output mcr_word_t      softIronCoef11,
    output mcr_word_t      softIronCoef12,
    output mcr_word_t      softIronCoef21
);

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    // Map a page address onto a slot; slot NUM_REGS means no hit
    function automatic mcr_idx_t slotOf(input mcr_byte_t addr);
        mcr_idx_t idx;
        idx = 4'd12;
        if (addr == `MCR_ADDR_SENS_LOW) begin
            idx = 4'd0;
        end else if (addr == `MCR_ADDR_SENS_HIGH) begin
            idx = 4'd1;
        end else if (addr == `MCR_ADDR_HIX_LOW) begin
            idx = 4'd2;
        end else if (addr == `MCR_ADDR_HIX_HIGH) begin
            idx = 4'd3;
        end else if (addr == `MCR_ADDR_HIY_LOW) begin
            idx = 4'd4;
        end else if (addr == `MCR_ADDR_HIY_HIGH) begin
            idx = 4'd5;
        end else if (addr == `MCR_ADDR_HIZ_LOW) begin
            idx = 4'd6;
        end else if (addr == `MCR_ADDR_HIZ_HIGH) begin
            idx = 4'd7;
        end else if (addr == `MCR_ADDR_C11_LOW) begin
            idx = 4'd8;
        end else if (addr == `MCR_ADDR_C11_HIGH) begin
            idx = 4'd9;
        end else if (addr == `MCR_ADDR_C12_LOW) begin
            idx = 4'd10;
        end else if (addr == `MCR_ADDR_C12_HIGH) begin
            idx = 4'd11;
        end
        return idx;
    endfunction

    // Reset value of each slot, low byte at even index
    function automatic mcr_byte_t resetOf(input int idx);
        mcr_byte_t val;
        val = `MCR_RST_ZERO;
        if (idx == 0) begin
            val = `MCR_RST_SENS_LOW;
        end else if (idx == 1) begin
            val = `MCR_RST_SENS_HIGH;
        end else if (idx == 9) begin
            val = `MCR_RST_C11_HIGH;
        end
        return val;
    endfunction

    // Only page zero reaches this bank; other pages never see a hit
    wire logic     pageZero = (pageSel == `MCR_PAGE_ZERO);
    wire mcr_idx_t slot     = slotOf(pageAddr);
    wire logic     slotHit  = pageZero && (slot != 4'd12);

    assign pageHit = slotHit;

    // ****************************************************************
    // Byte storage
    // ****************************************************************
    mcr_byte_t bytes [`MCR_NUM_REGS];

    // One byte register per slot, each with its own reset value
    for (genvar i = 0; i < `MCR_NUM_REGS; i++) begin : g_byte
        mcr_byte_reg #(
            .RESET_VALUE (resetOf(i))
        ) u_byte (
            .core_clk    (core_clk),
            .reset       (reset),
            .writeEnable (pageWrite && slotHit && (slot == mcr_idx_t'(i))),
            .writeData   (pageWriteData),
            .value       (bytes[i])
        );
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    mcr_byte_t readDataReg;
    mcr_byte_t readDataNext;

    // Unmapped addresses and other pages read as zero
    assign readDataNext = slotHit ? bytes[slot] : 8'h00;

    // Registered read data, updated on each read strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            readDataReg <= 8'h00;
        end else if (pageRead) begin
            readDataReg <= readDataNext;
        end
    end

    assign pageReadData = readDataReg;

    // ****************************************************************
    // Word assembly for the state machine
    // ****************************************************************
    // Lower address feeds the low half
    assign extMagSensitivity = {bytes[1], bytes[0]};
    assign hardIronOffsetX   = {bytes[3], bytes[2]};
    assign hardIronOffsetY   = {bytes[5], bytes[4]};
    assign hardIronOffsetZ   = {bytes[7], bytes[6]};
    assign softIronCoef11    = {bytes[9], bytes[8]};
    // Symmetric matrix: a single store drives both off-diagonal slots
    assign softIronCoef12    = {bytes[11], bytes[10]};
    assign softIronCoef21    = softIronCoef12;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_sensReset;
        @(posedge core_clk) $fell(reset) |-> extMagSensitivity == 16'h1624;
    endproperty
    a_sensReset: assert property (p_sensReset) else $error("sensitivity reset");

    property p_sensHighWrite;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageZero && pageAddr == 8'hBB
            |=> extMagSensitivity[15:8] == $past(pageWriteData);
    endproperty
    a_sensHighWrite: assert property (p_sensHighWrite) else $error("BB write lost");

    property p_offXWrite;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageZero && pageAddr == 8'hC0
            |=> hardIronOffsetX[7:0] == $past(pageWriteData);
    endproperty
    a_offXWrite: assert property (p_offXWrite) else $error("C0 write lost");

    property p_offYReset;
        @(posedge core_clk) $fell(reset) |-> hardIronOffsetY == 16'h0000;
    endproperty
    a_offYReset: assert property (p_offYReset) else $error("Y offset reset wrong");

    property p_offZWrite;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageZero && pageAddr == 8'hC5
            |=> hardIronOffsetZ[15:8] == $past(pageWriteData);
    endproperty
    a_offZWrite: assert property (p_offZWrite) else $error("C5 write lost");

    property p_c11Reset;
        @(posedge core_clk) $fell(reset) |-> softIronCoef11 == 16'h3C00;
    endproperty
    a_c11Reset: assert property (p_c11Reset) else $error("coef 11 reset wrong");

    property p_symmetric;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageZero && pageAddr == 8'hC9
            |=> softIronCoef21[15:8] == $past(pageWriteData) && softIronCoef12 == softIronCoef21;
    endproperty
    a_symmetric: assert property (p_symmetric) else $error("coef 21 mismatch");

    property p_readBack;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageZero && pageAddr == 8'hC2 ##1 pageRead && pageZero
            && pageAddr == 8'hC2 && !pageWrite |=> pageReadData == $past(pageWriteData, 2);
    endproperty
    a_readBack: assert property (p_readBack) else $error("read back mismatch");

    property p_otherPage;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageSel != 4'h0 |=> $stable(softIronCoef11) && $stable(hardIronOffsetX);
    endproperty
    a_otherPage: assert property (p_otherPage) else $error("write leaked");

    property p_sensLowWrite;
        @(posedge core_clk) disable iff (reset)
        pageWrite && pageZero && pageAddr == `MCR_ADDR_SENS_LOW
            |=> extMagSensitivity[7:0] == $past(pageWriteData);
    endproperty
    a_sensLowWrite: assert property (p_sensLowWrite) else $error("BA write lost");

    property p_refusedRead;
        @(posedge core_clk) disable iff (reset)
        pageRead && !pageHit |=> pageReadData == 8'h00;
    endproperty
    a_refusedRead: assert property (p_refusedRead) else $error("refused read");

    // Read data must stand between strobes, the host samples it late
    property p_readStands;
        @(posedge core_clk) disable iff (reset)
        !pageRead |=> $stable(pageReadData);
    endproperty
    a_readStands: assert property (p_readStands) else $error("read data moved");

endmodule

// ### tb/mcr_host_model.sv
// Host side model: walks the page window of the calibration bank.
// Assumes the bank takes its strobes on the rising edge of core_clk.
`timescale 1ns/1ns
module mcr_host_model
    import mcr_pkg::*;
(
    // Clock
    input  wire logic      core_clk,
    // Page window
    output logic [3:0]     pageSel,
    output mcr_byte_t      pageAddr,
    output logic           pageWrite,
    output logic           pageRead,
    output mcr_byte_t      pageWriteData,
    input  wire mcr_byte_t pageReadData
);
    // Window idle at time zero
    initial begin
        pageSel = 4'h0;
        pageAddr = 8'h00;
        pageWrite = 1'b0;
        pageRead = 1'b0;
        pageWriteData = 8'h00;
    end

    // One byte written; page and offset held through the taking edge
    task automatic host_write(input logic [3:0] page, input mcr_byte_t addr,
                              input mcr_byte_t data);
        @(negedge core_clk);
        pageSel = page;
        pageAddr = addr;
        pageWriteData = data;
        pageWrite = 1'b1;
        @(negedge core_clk);
        pageWrite = 1'b0;
        pageWriteData = ~data; // Released data never repeats the last byte
    endtask

    // One byte read; answer is registered on the taking edge and sampled half a cycle later
    task automatic host_read(input logic [3:0] page, input mcr_byte_t addr,
                             output mcr_byte_t data);
        @(negedge core_clk);
        pageSel = page;
        pageAddr = addr;
        pageRead = 1'b1;
        @(negedge core_clk);
        pageRead = 1'b0;
        data = pageReadData;
    endtask

    // Write on one edge, read the same byte back on the very next edge
    task automatic host_write_read(input mcr_byte_t addr, input mcr_byte_t data,
                                   output mcr_byte_t seen);
        @(negedge core_clk);
        pageSel = 4'h0;
        pageAddr = addr;
        pageWriteData = data;
        pageWrite = 1'b1;
        @(negedge core_clk);
        pageWrite = 1'b0;
        pageRead = 1'b1;
        @(negedge core_clk);
        pageRead = 1'b0;
        pageWriteData = ~data;
        seen = pageReadData;
    endtask
endmodule

// ### tb/mag_calibration_regs_test.sv
// Self-checking bench for the magnetometer calibration register bank.
// Assumes mcr_pkg is compiled first; the host model drives the window.
`timescale 1ns/1ns
module mag_calibration_regs_test;
    import mcr_pkg::*;
    // Clock, reset and window
    logic       core_clk = 1'b0;
    logic       reset = 1'b1;
    logic [3:0] pageSel;
    mcr_byte_t  pageAddr, pageWriteData, pageReadData, got;
    logic       pageWrite, pageRead, pageHit;
    mcr_word_t  extMagSensitivity, hardIronOffsetX, hardIronOffsetY, hardIronOffsetZ;
    mcr_word_t  softIronCoef11, softIronCoef12, softIronCoef21;
    int         fails = 0;
    int         checked = 0;
    // Offsets and defaults, lower byte first
    mcr_byte_t  addrTab [12] = '{8'hBA, 8'hBB, 8'hC0, 8'hC1, 8'hC2, 8'hC3,
                                 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9};
    mcr_byte_t  rstTab [12] = '{8'h24, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h00};
    logic [3:0] refPage [4] = '{4'h1, 4'hF, 4'h0, 4'h0};
    mcr_byte_t  refAddr [4] = '{8'hBA, 8'hC9, 8'hBC, 8'hCA};
    mcr_byte_t  expByte [12];

    // 25 MHz core clock
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    mcr_calib_regs DUT (.core_clk, .reset, .pageSel, .pageAddr, .pageWrite, .pageRead,
        .pageWriteData, .pageReadData, .pageHit, .extMagSensitivity, .hardIronOffsetX,
        .hardIronOffsetY, .hardIronOffsetZ, .softIronCoef11, .softIronCoef12,
        .softIronCoef21);
    mcr_host_model host (.core_clk, .pageSel, .pageAddr, .pageWrite, .pageRead,
        .pageWriteData, .pageReadData);

    // ************************************************************
    // Compare and report
    // ************************************************************
    task automatic check_byte(input string what, input mcr_byte_t exp, input mcr_byte_t seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_word(input string what, input mcr_word_t exp, input mcr_word_t seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // All words against the shadow bytes, higher offset on top
    task automatic check_words;
        check_word("sensitivity", {expByte[1], expByte[0]}, extMagSensitivity);
        check_word("offset x", {expByte[3], expByte[2]}, hardIronOffsetX);
        check_word("offset y", {expByte[5], expByte[4]}, hardIronOffsetY);
        check_word("offset z", {expByte[7], expByte[6]}, hardIronOffsetZ);
        check_word("coef 11", {expByte[9], expByte[8]}, softIronCoef11);
        check_word("coef 12", {expByte[11], expByte[10]}, softIronCoef12);
        check_word("coef 21", {expByte[11], expByte[10]}, softIronCoef21);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: the whole run is far shorter than this
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        give_verdict;
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        // Defaults at every offset
        expByte = rstTab;
        for (int i = 0; i < 12; i++) begin
            host.host_read(4'h0, addrTab[i], got);
            check_byte("default", rstTab[i], got);
            check_bit("hit", 1'b1, pageHit);
        end
        check_word("sensitivity default", 16'h1624, extMagSensitivity);
        check_words;
        // Distinct bytes everywhere, words follow each write
        for (int i = 0; i < 12; i++) begin
            expByte[i] = 8'h5A ^ mcr_byte_t'(i * 23);
            host.host_write(4'h0, addrTab[i], expByte[i]);
            check_words;
        end
        for (int i = 0; i < 12; i++) begin
            host.host_read(4'h0, addrTab[i], got);
            check_byte("readback", expByte[i], got);
        end
        // Lower half alone rewritten; upper half must stand
        expByte[2] = 8'hA5;
        host.host_write(4'h0, 8'hC0, 8'hA5);
        check_words;
        // Other pages and unmapped offsets change nothing and read zero
        for (int i = 0; i < 4; i++) begin
            host.host_write(refPage[i], refAddr[i], 8'hFF);
            host.host_read(refPage[i], refAddr[i], got);
            check_byte("refused read", 8'h00, got);
            check_bit("refused hit", 1'b0, pageHit);
            check_words;
        end
        // Write then read with no idle cycle between them
        expByte[4] = 8'h3E;
        host.host_write_read(8'hC2, 8'h3E, got);
        check_byte("write then read", 8'h3E, got);
        check_words;
        // Reset in mid-run restores the defaults
        @(negedge core_clk);
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        expByte = rstTab;
        check_byte("read data in reset", 8'h00, pageReadData);
        check_words;
        host.host_read(4'h0, 8'hC7, got);
        check_byte("coef 11 high default", 8'h3C, got);
        give_verdict;
    end
endmodule
